//--- hdl/scirq_defines.svh
// constants for the serial controller interrupt and transfer request block
`ifndef SCIRQ_DEFINES_SVH
`define SCIRQ_DEFINES_SVH
`define SCIRQ_A_COND_A 8'h00
`define SCIRQ_A_COND_B 8'h01
`define SCIRQ_A_VECTOR 8'h02
`define SCIRQ_A_RESET_CMD 8'h03
`define SCIRQ_A_EXT_CTRL 8'h04
`define SCIRQ_A_ENHANCE 8'h05
`define SCIRQ_A_PEND_CLR 8'h06
`define SCIRQ_A_COMMAND 8'h07
`define SCIRQ_A_STATUS_A 8'h08
`define SCIRQ_A_STATUS_B 8'h09
`define SCIRQ_A_PENDING 8'h0a
`define SCIRQ_A_VEC_RD_A 8'h0b
`define SCIRQ_A_VEC_RD_B 8'h0c
`define SCIRQ_C_EXT_IE 0
`define SCIRQ_C_TX_IE 1
`define SCIRQ_C_DTR 2
`define SCIRQ_C_RXM_LO 3
`define SCIRQ_C_RXM_HI 4
`define SCIRQ_C_WR_RX 5
`define SCIRQ_C_WR_FN 6
`define SCIRQ_C_WR_EN 7
`define SCIRQ_R_VIS 0
`define SCIRQ_R_MIE 3
`define SCIRQ_X_ENH_ACC 0
`define SCIRQ_E_RX_FOUR 3
`define SCIRQ_E_DTR_REQ 4
`define SCIRQ_E_TX_ALL 5
`define SCIRQ_K_SW_ACK 0
`define SCIRQ_K_RST_IUS 1
`define SCIRQ_T_TX 0
`define SCIRQ_T_RX 1
`define SCIRQ_T_EXT 2
`define SCIRQ_RST_BYTE 8'h00
`define SCIRQ_RST_SRC 6'h00
`define SCIRQ_CODE_NONE 3'h3
`endif

//--- hdl/scirq_pkg.sv
// types shared by the interrupt and transfer request block
package scirq_pkg;
   typedef enum logic [1:0] {RXM_OFF, RXM_FIRST, RXM_ALL, RXM_SPECIAL} scirq_rxmode_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic we;
      logic re;
   } scirq_bus_req_t;
   typedef struct packed {
      logic tx_top_empty;
      logic tx_all_empty;
      logic tx_write;
      logic tx_room;
      logic rx_char;
      logic rx_special;
      logic rx_four;
      logic rx_avail;
      logic data_access;
      logic cts_n;
      logic carrier_detect_n;
      logic sync_n;
      logic brk_abort;
      logic end_of_poll;
      logic tx_underrun;
      logic baud_generator_zero;
   } scirq_chan_in_t;
   typedef struct packed {
      logic waitreq_n;
      logic dtr_req_n;
   } scirq_chan_out_t;
endpackage

//--- hdl/scirq_ctrl.sv
// interrupt daisy chain, vectors, polling status and wait/request for two channels
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "scirq_defines.svh"
module scirq_ctrl #(
   parameter int NCH = 2
) (
   input wire logic clk,
   input wire logic rst,
   input wire scirq_pkg::scirq_bus_req_t bus,
   output logic [7:0] rdata,
   input wire scirq_pkg::scirq_chan_in_t chan_in [NCH],
   output scirq_pkg::scirq_chan_out_t chan_out [NCH],
   input wire logic chain_priority_in,
   output logic chain_priority_out,
   output logic int_n,
   input wire logic irq_acknowledge_n,
   output logic [7:0] ack_data,
   output logic ack_data_oe
);
   import scirq_pkg::*;

   localparam int NSRC = 3 * NCH;

   logic [7:0] cond_q [NCH];
   logic [7:0] vector_q;
   logic [7:0] reset_cmd_q;
   logic [7:0] ext_ctrl_q;
   logic [7:0] enh_q;
   logic [NSRC-1:0] ip_q;
   logic [NSRC-1:0] ip_d;
   logic [NSRC-1:0] ius_q;
   logic [NSRC-1:0] ius_d;
   logic [NCH-1:0] first_arm_q;
   logic [NCH-1:0] tx_written_q;
   logic [NCH-1:0] rx_spec_q;
   logic [4:0] ext_prev_q [NCH];
   logic ack_prev_q;
   logic [7:0] ack_data_q;
   logic ack_oe_q;
   logic [7:0] rdata_q;

   logic [NSRC-1:0] src_set;
   logic [NSRC-1:0] ie_mask;
   logic [NSRC-1:0] req;
   logic [NSRC-1:0] win;
   logic [NCH-1:0] tx_ev;
   logic [NCH-1:0] rx_chr_ev;
   logic [NCH-1:0] rx_sp_ev;
   logic [NCH-1:0] ext_ev;
   logic [4:0] ext_now [NCH];
   logic master_irq_enable;
   logic hw_ack;
   logic sw_ack;
   logic ack_take;
   logic wr_cmd;
   logic wr_clr;
   logic enh_open;

   // lowest index is highest priority: channel A before B, tx, rx, ext
   function automatic logic [NSRC-1:0] first_one(input logic [NSRC-1:0] v);
      logic [NSRC-1:0] r;
      logic found;
      r = '0;
      found = 1'b0;
      for (int i = 0; i < NSRC; i++) begin
         if (v[i] && !found) begin
            r[i] = 1'b1;
            found = 1'b1;
         end
      end
      return r;
   endfunction

   // three status bits: channel A adds four; tx 0, ext 1, rx 2, special 3
   function automatic logic [7:0] vec_mod(input logic [7:0] v, input logic [NSRC-1:0] hot,
                                          input logic [NCH-1:0] spec);
      logic [2:0] code;
      code = `SCIRQ_CODE_NONE;
      for (int c = NCH - 1; c >= 0; c--) begin
         if (hot[3*c + `SCIRQ_T_TX]) begin
            code = {c == 0, 2'b00};
         end
         if (hot[3*c + `SCIRQ_T_EXT]) begin
            code = {c == 0, 2'b01};
         end
         if (hot[3*c + `SCIRQ_T_RX]) begin
            code = {c == 0, 1'b1, spec[c]};
         end
      end
      return {v[7:4], code, v[0]};
   endfunction

   assign master_irq_enable = reset_cmd_q[`SCIRQ_R_MIE];
   assign enh_open = ext_ctrl_q[`SCIRQ_X_ENH_ACC];
   assign wr_cmd = bus.we && (bus.addr == `SCIRQ_A_COMMAND);
   assign wr_clr = bus.we && (bus.addr == `SCIRQ_A_PEND_CLR);

   // acknowledge is taken on the falling edge of the strobe or by command
   assign hw_ack = !irq_acknowledge_n && ack_prev_q;
   assign sw_ack = wr_cmd && bus.wdata[`SCIRQ_K_SW_ACK];
   // a higher device that requests holds our chain input low, so nothing is taken
   assign ack_take = (hw_ack || sw_ack) && chain_priority_in;

   // per channel event detection
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         scirq_rxmode_t m;
         m = scirq_rxmode_t'(cond_q[c][`SCIRQ_C_RXM_HI:`SCIRQ_C_RXM_LO]);
         ext_now[c] = {chan_in[c].cts_n, chan_in[c].carrier_detect_n, chan_in[c].sync_n,
                       chan_in[c].brk_abort, chan_in[c].end_of_poll};
         tx_ev[c] = cond_q[c][`SCIRQ_C_TX_IE] && tx_written_q[c]
                    && (enh_q[`SCIRQ_E_TX_ALL] ? chan_in[c].tx_all_empty
                                               : chan_in[c].tx_top_empty);
         rx_chr_ev[c] = 1'b0;
         case (m)
            RXM_FIRST: begin
               rx_chr_ev[c] = chan_in[c].rx_char && first_arm_q[c];
            end
            RXM_ALL: begin
               rx_chr_ev[c] = chan_in[c].rx_char;
            end
            RXM_SPECIAL: begin
               rx_chr_ev[c] = enh_q[`SCIRQ_E_RX_FOUR] && chan_in[c].rx_four;
            end
            default: begin
               rx_chr_ev[c] = 1'b0;
            end
         endcase
         // special conditions share the rx source, told apart only by vector status
         rx_sp_ev[c] = (m != RXM_OFF) && chan_in[c].rx_special
                       && ((m != RXM_FIRST) || !first_arm_q[c]);
         // any level change counts, so abort and poll end fire at start and finish
         ext_ev[c] = cond_q[c][`SCIRQ_C_EXT_IE] && ((ext_now[c] != ext_prev_q[c])
                     || chan_in[c].tx_underrun || chan_in[c].baud_generator_zero);
         src_set[3*c + `SCIRQ_T_TX] = tx_ev[c];
         src_set[3*c + `SCIRQ_T_RX] = rx_chr_ev[c] || rx_sp_ev[c];
         src_set[3*c + `SCIRQ_T_EXT] = ext_ev[c];
         ie_mask[3*c + `SCIRQ_T_TX] = cond_q[c][`SCIRQ_C_TX_IE];
         ie_mask[3*c + `SCIRQ_T_RX] = (m != RXM_OFF);
         ie_mask[3*c + `SCIRQ_T_EXT] = cond_q[c][`SCIRQ_C_EXT_IE];
      end
   end

   // set wins over the software clear; a disabled source holds no pending bit
   always_comb begin
      ip_d = ((ip_q & ~({NSRC{wr_clr}} & bus.wdata[NSRC-1:0])) | src_set) & ie_mask;
   end

   // internal daisy chain: a served source blocks itself and everything below
   always_comb begin
      logic blk;
      blk = 1'b0;
      for (int i = 0; i < NSRC; i++) begin
         blk = blk | ius_q[i];
         req[i] = ip_q[i] && !blk && master_irq_enable;
      end
      win = first_one(req);
   end

   always_comb begin
      ius_d = ius_q;
      if (wr_cmd && bus.wdata[`SCIRQ_K_RST_IUS]) begin
         ius_d = ius_q & ~first_one(ius_q);
      end
      if (ack_take) begin
         ius_d = ius_d | win;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ip_q <= `SCIRQ_RST_SRC;
         ius_q <= `SCIRQ_RST_SRC;
      end else begin
         ip_q <= ip_d;
         ius_q <= ius_d;
      end
   end

   // software registers
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int c = 0; c < NCH; c++) begin
            cond_q[c] <= `SCIRQ_RST_BYTE;
         end
         vector_q <= `SCIRQ_RST_BYTE;
         reset_cmd_q <= `SCIRQ_RST_BYTE;
         ext_ctrl_q <= `SCIRQ_RST_BYTE;
         enh_q <= `SCIRQ_RST_BYTE;
      end else if (bus.we) begin
         if (bus.addr == `SCIRQ_A_COND_A) begin
            cond_q[0] <= bus.wdata;
         end else if (bus.addr == `SCIRQ_A_COND_B) begin
            cond_q[NCH-1] <= bus.wdata;
         end else if (bus.addr == `SCIRQ_A_VECTOR) begin
            vector_q <= bus.wdata;
         end else if (bus.addr == `SCIRQ_A_RESET_CMD) begin
            reset_cmd_q <= bus.wdata;
         end else if (bus.addr == `SCIRQ_A_EXT_CTRL) begin
            ext_ctrl_q <= bus.wdata;
         end else if (bus.addr == `SCIRQ_A_ENHANCE && enh_open) begin
            enh_q <= bus.wdata;
         end
      end
   end

   // per channel sequencing flags
   always_ff @(posedge clk) begin
      if (rst) begin
         first_arm_q <= '0;
         tx_written_q <= '0;
         rx_spec_q <= '0;
         for (int c = 0; c < NCH; c++) begin
            ext_prev_q[c] <= 5'h1f;
         end
      end else begin
         for (int c = 0; c < NCH; c++) begin
            ext_prev_q[c] <= ext_now[c];
            tx_written_q[c] <= chan_in[c].tx_write || (tx_written_q[c] && !tx_ev[c]);
            rx_spec_q[c] <= rx_sp_ev[c] || (rx_spec_q[c] && !rx_chr_ev[c]
                            && ip_d[3*c + `SCIRQ_T_RX]);
            // rewriting the condition register re-arms first-character mode
            if (bus.we && bus.addr == ((c == 0) ? `SCIRQ_A_COND_A : `SCIRQ_A_COND_B)) begin
               first_arm_q[c] <= 1'b1;
            end else if (rx_chr_ev[c]) begin
               first_arm_q[c] <= 1'b0;
            end
         end
      end
   end

   // vector on the data bus while the acknowledge strobe stays low
   always_ff @(posedge clk) begin
      if (rst) begin
         ack_prev_q <= 1'b1;
         ack_data_q <= `SCIRQ_RST_BYTE;
         ack_oe_q <= 1'b0;
      end else begin
         ack_prev_q <= irq_acknowledge_n;
         if (hw_ack && ack_take && (|win)) begin
            ack_data_q <= reset_cmd_q[`SCIRQ_R_VIS] ? vec_mod(vector_q, win, rx_spec_q) : vector_q;
            ack_oe_q <= 1'b1;
         end else if (irq_acknowledge_n) begin
            ack_oe_q <= 1'b0;
         end
      end
   end

   // read port: data stand only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= `SCIRQ_RST_BYTE;
      end else if (!bus.re) begin
         rdata_q <= `SCIRQ_RST_BYTE;
      end else if (bus.addr == `SCIRQ_A_COND_A) begin
         rdata_q <= cond_q[0];
      end else if (bus.addr == `SCIRQ_A_COND_B) begin
         rdata_q <= cond_q[NCH-1];
      end else if (bus.addr == `SCIRQ_A_RESET_CMD) begin
         rdata_q <= reset_cmd_q;
      end else if (bus.addr == `SCIRQ_A_EXT_CTRL) begin
         rdata_q <= ext_ctrl_q;
      end else if (bus.addr == `SCIRQ_A_ENHANCE) begin
         rdata_q <= enh_open ? enh_q : `SCIRQ_RST_BYTE;
      end else if (bus.addr == `SCIRQ_A_STATUS_A) begin
         rdata_q <= {ext_now[0], chan_in[0].tx_room, ip_q[`SCIRQ_T_EXT], chan_in[0].rx_avail};
      end else if (bus.addr == `SCIRQ_A_STATUS_B) begin
         rdata_q <= {ext_now[NCH-1], chan_in[NCH-1].tx_room, ip_q[3 + `SCIRQ_T_EXT],
                     chan_in[NCH-1].rx_avail};
      end else if (bus.addr == `SCIRQ_A_PENDING) begin
         rdata_q <= {2'b00, ip_q};
      end else if (bus.addr == `SCIRQ_A_VEC_RD_A) begin
         rdata_q <= vector_q;
      end else if (bus.addr == `SCIRQ_A_VEC_RD_B) begin
         rdata_q <= reset_cmd_q[`SCIRQ_R_VIS] ? vec_mod(vector_q, first_one(ip_q), rx_spec_q)
                                              : vector_q;
      end else begin
         rdata_q <= `SCIRQ_RST_BYTE;
      end
   end

   // pending status with tx and rx bits tells a poller what to move
   assign rdata = rdata_q;
   assign ack_data = ack_data_q;
   assign ack_data_oe = ack_oe_q;

   // released for the whole acknowledge cycle so a higher source may nest
   assign int_n = !((|req) && chain_priority_in && irq_acknowledge_n);
   assign chain_priority_out = chain_priority_in && !(|ius_q) && !(|ip_q);

   // wait/request and terminal-ready/request per channel
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         logic rdy;
         logic en;
         logic fn;
         rdy = cond_q[c][`SCIRQ_C_WR_RX] ? chan_in[c].rx_avail : chan_in[c].tx_room;
         en = cond_q[c][`SCIRQ_C_WR_EN];
         fn = cond_q[c][`SCIRQ_C_WR_FN];
         // wait stretches only the data access that cannot be served yet
         chan_out[c].waitreq_n = !(en && (fn ? rdy : (chan_in[c].data_access && !rdy)));
         chan_out[c].dtr_req_n = enh_q[`SCIRQ_E_DTR_REQ] ? !(en && fn && chan_in[c].tx_room)
                                                         : !cond_q[c][`SCIRQ_C_DTR];
      end
   end
endmodule
`default_nettype wire

//--- verif/scirq_host.sv
// host model: answers an interrupt with a hardware acknowledge
`timescale 1ns/1ps
`default_nettype none
module scirq_host (
   input wire logic clk,
   input wire logic rst,
   input wire logic en,
   input wire logic int_n,
   output logic ack_n
);
   logic [1:0] cnt_q;
   // ack stays low three cycles so the vector can be taken
   always_ff @(posedge clk) begin
      if (rst) begin
         ack_n <= 1'b1;
         cnt_q <= 2'h0;
      end else if (cnt_q != 2'h0) begin
         cnt_q <= cnt_q - 2'h1;
         ack_n <= (cnt_q == 2'h1);
      end else if (en && !int_n && ack_n) begin
         ack_n <= 1'b0;
         cnt_q <= 2'h3;
      end
   end
endmodule
`default_nettype wire

//--- verif/scirq_ctrl_chk.sv
// port checker for the interrupt and transfer request block
`timescale 1ns/1ps
`default_nettype none
module scirq_ctrl_chk #(
   parameter int NCH = 2
) (
   input wire logic clk,
   input wire logic rst,
   input wire scirq_pkg::scirq_bus_req_t bus,
   input wire logic [7:0] rdata,
   input wire scirq_pkg::scirq_chan_in_t chan_in [NCH],
   input wire scirq_pkg::scirq_chan_out_t chan_out [NCH],
   input wire logic chain_priority_in,
   input wire logic chain_priority_out,
   input wire logic int_n,
   input wire logic irq_acknowledge_n,
   input wire logic [7:0] ack_data,
   input wire logic ack_data_oe
);
   import scirq_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   AST_INT_CHAIN: assert property (!int_n |-> chain_priority_in)
      else $error("request while chain input low");
   AST_INT_OUT: assert property (!int_n |-> !chain_priority_out)
      else $error("chain output high while requesting");
   AST_CHAIN_PASS: assert property (!chain_priority_in |-> !chain_priority_out)
      else $error("chain output high with chain input low");
   AST_ACK_REL: assert property (!irq_acknowledge_n |-> int_n)
      else $error("request held during acknowledge");
   AST_ACK_LOAD: assert property (!int_n ##1 (!irq_acknowledge_n && chain_priority_in) |=> ack_data_oe)
      else $error("vector not driven after acknowledge");
   AST_OE_HOLD: assert property (ack_data_oe && !irq_acknowledge_n |=> ack_data_oe && $stable(ack_data))
      else $error("vector dropped or changed in acknowledge");
   AST_OE_DROP: assert property (ack_data_oe && irq_acknowledge_n |=> !ack_data_oe)
      else $error("vector drive outlives acknowledge");
   AST_IUS_BLOCK: assert property (ack_data_oe |-> !chain_priority_out)
      else $error("chain output high while served");
   AST_RD_IDLE: assert property (!bus.re |=> rdata == 8'h00)
      else $error("read data without read strobe");
endmodule
bind scirq_ctrl scirq_ctrl_chk #(.NCH(NCH)) u_chk (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
   .chan_in(chan_in), .chan_out(chan_out), .chain_priority_in(chain_priority_in),
   .chain_priority_out(chain_priority_out), .int_n(int_n), .irq_acknowledge_n(irq_acknowledge_n),
   .ack_data(ack_data), .ack_data_oe(ack_data_oe));
`default_nettype wire

//--- verif/scirq_tb.sv
// self-checking bench for the interrupt and transfer request block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import scirq_pkg::*;
   localparam logic [15:0] TTE = 16'h8000;
   localparam logic [15:0] TAE = 16'h4000;
   localparam logic [15:0] TW = 16'h2000;
   localparam logic [15:0] TR = 16'h1000;
   localparam logic [15:0] RC = 16'h0800;
   localparam logic [15:0] RS = 16'h0400;
   localparam logic [15:0] DA = 16'h0080;
   localparam logic [15:0] CTS = 16'h0040;
   localparam logic [15:0] BRK = 16'h0008;
   localparam logic [15:0] BGZ = 16'h0001;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cin = 1'b1;
   logic hen = 1'b0;
   logic ack_n, cout, int_n, oe;
   logic [7:0] rdata, vec;
   scirq_bus_req_t b = '0;
   scirq_chan_in_t ci [2];
   scirq_chan_out_t co [2];
   int mismatches = 0;
   int compares = 0;
   always #2 clk = ~clk;
   scirq_ctrl #(.NCH(2)) dut (.clk(clk), .rst(rst), .bus(b), .rdata(rdata), .chan_in(ci), .chan_out(co),
      .chain_priority_in(cin), .chain_priority_out(cout), .int_n(int_n), .irq_acknowledge_n(ack_n),
      .ack_data(vec), .ack_data_oe(oe));
   scirq_host host (.clk(clk), .rst(rst), .en(hen), .int_n(int_n), .ack_n(ack_n));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      b.addr <= a;
      b.wdata <= d;
      b.we <= 1'b1;
      @(posedge clk);
      b.we <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      b.addr <= a;
      b.re <= 1'b1;
      @(posedge clk);
      b.re <= 1'b0;
      #1;
      chk("rdata", e, rdata);
   endtask
   // xor toggles a field and back: a pulse on event inputs, two edges on pins
   task automatic ev(input int c, input logic [15:0] m);
      @(posedge clk);
      ci[c] <= ci[c] ^ m;
      @(posedge clk);
      ci[c] <= ci[c] ^ m;
      #1;
   endtask
   task automatic final_report;
      if (mismatches == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #20000;
      mismatches++;
      final_report;
   end
   initial begin
      ci[0] = 16'h0070;
      ci[1] = 16'h0070;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk("int_n", 8'h01, int_n);
      chk("chain_out", 8'h01, cout);
      wr(8'h02, 8'hf1);
      rd(8'h0b, 8'hf1);
      wr(8'h00, 8'h02);
      ev(0, TTE);
      rd(8'h0a, 8'h00);
      ev(0, TW);
      ev(0, TTE);
      rd(8'h0a, 8'h01);
      chk("int_n", 8'h01, int_n);
      chk("chain_out", 8'h00, cout);
      ev(1, RC);
      rd(8'h0a, 8'h01);
      wr(8'h03, 8'h08);
      chk("int_n", 8'h00, int_n);
      @(posedge clk);
      cin <= 1'b0;
      #1;
      chk("int_n", 8'h01, int_n);
      chk("chain_out", 8'h00, cout);
      @(posedge clk);
      cin <= 1'b1;
      wr(8'h01, 8'h08);
      ev(1, RC);
      wr(8'h03, 8'h09);
      rd(8'h0c, 8'hf9);
      rd(8'h0b, 8'hf1);
      wr(8'h06, 8'h01);
      rd(8'h0c, 8'hf5);
      wr(8'h03, 8'h08);
      @(posedge clk);
      hen <= 1'b1;
      repeat (20) begin
         @(posedge clk);
         #1;
         if (oe === 1'b1) break;
      end
      chk("ack_data", 8'hf1, vec);
      chk("chain_out", 8'h00, cout);
      @(posedge clk);
      hen <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
      chk("int_n", 8'h01, int_n);
      wr(8'h07, 8'h02);
      chk("int_n", 8'h00, int_n);
      wr(8'h07, 8'h01);
      chk("int_n", 8'h01, int_n);
      chk("chain_out", 8'h00, cout);
      wr(8'h07, 8'h02);
      wr(8'h06, 8'h10);
      chk("chain_out", 8'h01, cout);
      ev(1, RC);
      rd(8'h0a, 8'h00);
      ev(1, RS);
      rd(8'h0a, 8'h10);
      wr(8'h06, 8'h10);
      wr(8'h05, 8'h20);
      rd(8'h05, 8'h00);
      wr(8'h04, 8'h01);
      wr(8'h05, 8'h20);
      rd(8'h05, 8'h20);
      ev(0, TW);
      ev(0, TTE);
      rd(8'h0a, 8'h00);
      ev(0, TAE);
      rd(8'h0a, 8'h01);
      wr(8'h00, 8'h01);
      ev(0, BGZ);
      rd(8'h0a, 8'h04);
      wr(8'h06, 8'h04);
      ev(0, CTS);
      rd(8'h0a, 8'h04);
      wr(8'h06, 8'h04);
      @(posedge clk);
      ci[0] <= ci[0] ^ BRK;
      wr(8'h06, 8'h04);
      rd(8'h0a, 8'h00);
      @(posedge clk);
      ci[0] <= ci[0] ^ BRK;
      rd(8'h0a, 8'h04);
      wr(8'h00, 8'hc0);
      @(posedge clk);
      ci[0].tx_room <= 1'b1;
      #1;
      chk("waitreq_n", 8'h00, co[0].waitreq_n);
      wr(8'h05, 8'h10);
      chk("dtr_req_n", 8'h00, co[0].dtr_req_n);
      chk("waitreq_n_b", 8'h01, co[1].waitreq_n);
      chk("dtr_req_n_b", 8'h01, co[1].dtr_req_n);
      wr(8'h00, 8'h80);
      chk("waitreq_n", 8'h01, co[0].waitreq_n);
      @(posedge clk);
      ci[0] <= ci[0] ^ (DA | TR);
      #1;
      chk("waitreq_n", 8'h00, co[0].waitreq_n);
      final_report;
   end
endmodule
`default_nettype wire
